//--- inc/clk_ctrl_consts.svh
// timing counts, register offsets, field positions and reset values of the clock control block
// assumes a 25 MHz system clock and byte-wide registers on a 16-bit address port
`ifndef CLK_CTRL_CONSTS_SVH
`define CLK_CTRL_CONSTS_SVH

`define CLK_PERIOD_NS       40
`define STAB_MAIN_CYCLES    8000
`define PREDIV_DEFAULT      16

`define ADDR_PRESCALER12    16'h0020
`define ADDR_TIMER1         16'h0024
`define ADDR_PORT_CTRL2     16'h002F
`define ADDR_WDT_CTRL       16'h0039
`define ADDR_CPU_MODE       16'h003B

`define CPUM_SUB_DRIVE_BIT  3
`define CPUM_MAIN_STOP_BIT  5
`define CPUM_SYS_SUB_BIT    7
`define PCTL2_NO_RELOAD_BIT 6
`define WDT_STOP_DIS_BIT    6

`define CPUM_RESET          8'h00
`define PCTL2_RESET         8'h00
`define WDT_CTRL_RESET      8'h3F
`define TIMER1_RESET        8'h01
`define PRESCALER12_RESET   8'hFF
`define TIMER1_STOP_LOAD    8'h01
`define PRESCALER12_STOP_LD 8'hFF
`define WDT_PRELOAD_LOW     8'hFF

`endif

//--- inc/clk_ctrl_pkg.sv
// types shared by the clock control block
// assumes the constants header is compiled alongside
package clk_ctrl_pkg;
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } bus_req_t;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_STOPPED,
        ST_STABILIZE,
        ST_WAITING
    } power_state_t;
endpackage

//--- rtl/pin_sync.sv
// two-flop synchroniser with rising edge detect for a slow pin or oscillator input
// assumes the pin toggles well below half the system clock rate
module pin_sync (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic pin,
    output logic      level,
    output logic      rise
);
    logic meta_reg;
    logic sync_reg;
    logic last_reg;

    // the first flop feeds only the second one
    always_ff @(posedge clk) begin
        if (!nrst) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            last_reg <= 1'b0;
        end else begin
            meta_reg <= pin;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    assign level = sync_reg;
    assign rise  = sync_reg & ~last_reg;
endmodule

//--- rtl/stab_timer.sv
// first-stage divider, second-stage prescaler and timer 1 chain used for the stabilizing wait
// assumes tick is a one-cycle pulse per oscillator period, loads take priority over counting
`include "clk_ctrl_consts.svh"
module stab_timer #(
    parameter int PREDIV = `PREDIV_DEFAULT
) (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       tick,
    input  wire logic       run,
    input  wire logic       ld_pre,
    input  wire logic [7:0] pre_val,
    input  wire logic       ld_t1,
    input  wire logic [7:0] t1_val,
    input  wire logic [7:0] pre_reload,
    input  wire logic [7:0] t1_reload,
    output logic      [7:0] pre_cnt,
    output logic      [7:0] t1_cnt,
    output logic            underflow
);
    localparam int DW = (PREDIV > 1) ? $clog2(PREDIV) : 1;

    logic [DW-1:0] div_reg;
    logic [7:0]    pre_reg;
    logic [7:0]    t1_reg;
    logic          div_end;
    logic          pre_end;

    // a divider the counter width cannot hold is refused at elaboration
    if (PREDIV < 1 || PREDIV > 1024) begin : g_bad_prediv
        $error("stab_timer: PREDIV out of range");
    end

    assign div_end = run && tick && (div_reg == DW'(PREDIV - 1));
    assign pre_end = div_end && (pre_reg == 8'h00);

    // first stage divides the oscillator ticks
    always_ff @(posedge clk) begin
        if (!nrst) begin
            div_reg <= '0;
        end else if (ld_pre || ld_t1) begin
            div_reg <= '0;
        end else if (run && tick) begin
            div_reg <= div_end ? '0 : div_reg + DW'(1);
        end
    end

    // second-stage prescaler wraps to its reload value
    always_ff @(posedge clk) begin
        if (!nrst) begin
            pre_reg <= `PRESCALER12_RESET;
        end else if (ld_pre) begin
            pre_reg <= pre_val;
        end else if (div_end) begin
            pre_reg <= pre_end ? pre_reload : pre_reg - 8'h01;
        end
    end

    // timer 1 counts prescaler wraps and flags its own underflow
    always_ff @(posedge clk) begin
        if (!nrst) begin
            t1_reg    <= `TIMER1_RESET;
            underflow <= 1'b0;
        end else begin
            underflow <= 1'b0;
            if (ld_t1) begin
                t1_reg <= t1_val;
            end else if (pre_end) begin
                if (t1_reg == 8'h00) begin
                    t1_reg    <= t1_reload;
                    underflow <= 1'b1;
                end else begin
                    t1_reg <= t1_reg - 8'h01;
                end
            end
        end
    end

    assign pre_cnt = pre_reg;
    assign t1_cnt  = t1_reg;
endmodule

//--- rtl/stop_wait_clock_restore.sv
// clock control for stop and wait modes with oscillator restart and stabilizing wait
// assumes instruction strobes and interrupt requests come from logic on clk, clock pins are raw
//
// Overview of operation
// R01: interrupt stop release keeps CPU mode register
// R02: main clock release waits about 8,000 cycles
// R03: reset from wait restarts main, stops sub
// R04: reset pin held low until main stable; the block enables the cpu clock straight out of reset with no wait
// R05: CPU mode bit 3 keeps sub oscillator running
// R06: stop halts oscillation, external interrupt restarts
// R07: release reloads timer 1 01, prescaler FF
// R08: port control 2 bit 6 suppresses reload
// R09: suppressed reload keeps software-written counts
// R10: CPU clock withheld until timer 1 underflows
// R11: watchdog keeps counting during stop release
// R12: stop disable bit is set-only from software
// R13: timer 1 paced by prescaler on restarted oscillator
`include "clk_ctrl_consts.svh"
module stop_wait_clock_restore
    import clk_ctrl_pkg::*;
#(
    parameter int PREDIV = `PREDIV_DEFAULT
) (
    input  wire logic                  clk,
    input  wire logic                  nrst,
    input  wire clk_ctrl_pkg::bus_req_t bus_req,
    output logic                 [7:0] rd_data,
    input  wire logic                  stop_instruction,
    input  wire logic                  wait_instruction,
    input  wire logic                  ext_irq,
    input  wire logic                  int_irq,
    input  wire logic                  main_clock_input,
    input  wire logic                  sub_clock_input,
    output logic                       cpu_clk_en,
    output logic                       main_osc_en,
    output logic                       sub_osc_en,
    output logic                       sys_clk_sub,
    output logic                       wdt_underflow
);
    import clk_ctrl_pkg::*;

    localparam int STAB_NS = `STAB_MAIN_CYCLES * 1000 / 8000;

    power_state_t state_reg;
    power_state_t state_next;
    logic [7:0]   cpum_reg;
    logic [7:0]   pctl2_reg;
    logic [7:0]   wdt_ctrl_reg;
    logic [7:0]   pre_reload_reg;
    logic [7:0]   t1_reload_reg;
    logic [15:0]  wdt_cnt_reg;
    logic         main_rise;
    logic         sub_rise;
    logic         ext_rise;
    logic         osc_tick;
    logic         t1_under;
    logic [7:0]   pre_cnt;
    logic [7:0]   t1_cnt;
    logic         wr_pre;
    logic         wr_t1;
    logic         stop_release;
    logic         auto_reload;
    logic         ld_pre;
    logic         ld_t1;
    logic [7:0]   ld_pre_val;
    logic [7:0]   ld_t1_val;
    logic         stop_ok;

    // parameters the timer chain cannot serve are refused at elaboration
    if (PREDIV < 1) begin : g_bad_prediv
        $error("stop_wait_clock_restore: PREDIV must be positive");
    end
    if (STAB_NS < 1) begin : g_bad_stab
        $error("stop_wait_clock_restore: stabilizing time too short");
    end

    // pins from outside the clk domain are synchronised before use
    pin_sync u_main_sync (
        .clk   (clk),
        .nrst  (nrst),
        .pin   (main_clock_input),
        .level (),
        .rise  (main_rise)
    );
    pin_sync u_sub_sync (
        .clk   (clk),
        .nrst  (nrst),
        .pin   (sub_clock_input),
        .level (),
        .rise  (sub_rise)
    );
    pin_sync u_irq_sync (
        .clk   (clk),
        .nrst  (nrst),
        .pin   (ext_irq),
        .level (),
        .rise  (ext_rise)
    );

    // tick source follows the selected system clock
    assign osc_tick = cpum_reg[`CPUM_SYS_SUB_BIT] ? sub_rise : main_rise;  // see R13

    // write decode for the counter registers
    assign wr_pre = bus_req.wr && (bus_req.addr == `ADDR_PRESCALER12);
    assign wr_t1  = bus_req.wr && (bus_req.addr == `ADDR_TIMER1);

    // only an external interrupt can restart the stopped oscillator
    assign stop_release = (state_reg == ST_STOPPED) && ext_rise;  // see R06
    assign auto_reload  = stop_release && !pctl2_reg[`PCTL2_NO_RELOAD_BIT];  // see R08
    assign stop_ok      = !wdt_ctrl_reg[`WDT_STOP_DIS_BIT];

    // fixed reload on release wins over any software write in the same cycle
    assign ld_pre     = auto_reload || wr_pre;
    assign ld_t1      = auto_reload || wr_t1;
    assign ld_pre_val = auto_reload ? `PRESCALER12_STOP_LD : bus_req.wdata;  // see R07
    assign ld_t1_val  = auto_reload ? `TIMER1_STOP_LOAD : bus_req.wdata;  // see R07

    // without auto reload the counters simply keep what software left there
    stab_timer #(
        .PREDIV (PREDIV)
    ) u_stab (
        .clk        (clk),
        .nrst       (nrst),
        .tick       (osc_tick),
        .run        (state_reg != ST_STOPPED),  // see R09
        .ld_pre     (ld_pre),
        .pre_val    (ld_pre_val),
        .ld_t1      (ld_t1),
        .t1_val     (ld_t1_val),
        .pre_reload (pre_reload_reg),
        .t1_reload  (t1_reload_reg),
        .pre_cnt    (pre_cnt),
        .t1_cnt     (t1_cnt),
        .underflow  (t1_under)
    );

    // power state sequencing
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_RUN: begin
                if (stop_instruction && stop_ok) begin
                    state_next = ST_STOPPED;
                end else if (wait_instruction) begin
                    state_next = ST_WAITING;
                end
            end
            ST_STOPPED: begin
                if (stop_release) begin
                    state_next = ST_STABILIZE;  // see R02
                end
            end
            ST_STABILIZE: begin
                if (t1_under) begin
                    state_next = ST_RUN;  // see R10
                end
            end
            ST_WAITING: begin
                if (ext_rise || int_irq) begin
                    state_next = ST_RUN;
                end
            end
            default: state_next = ST_RUN;
        endcase
    end

    // reset always lands in run with main oscillator as system clock
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_reg <= ST_RUN;  // see R03
        end else begin
            state_reg <= state_next;
        end
    end

    // cpu mode register, untouched by entering or leaving stop
    always_ff @(posedge clk) begin
        if (!nrst) begin
            cpum_reg <= `CPUM_RESET;  // see R03
        end else if (bus_req.wr && bus_req.addr == `ADDR_CPU_MODE) begin
            cpum_reg <= bus_req.wdata;  // see R01
        end
    end

    // port control 2 carries the reload inhibit
    always_ff @(posedge clk) begin
        if (!nrst) begin
            pctl2_reg <= `PCTL2_RESET;
        end else if (bus_req.wr && bus_req.addr == `ADDR_PORT_CTRL2) begin
            pctl2_reg <= bus_req.wdata;  // see R08
        end
    end

    // stop disable bit can only be set, the rest is ordinary
    always_ff @(posedge clk) begin
        if (!nrst) begin
            wdt_ctrl_reg <= `WDT_CTRL_RESET;
        end else if (bus_req.wr && bus_req.addr == `ADDR_WDT_CTRL) begin
            wdt_ctrl_reg <= bus_req.wdata;
            wdt_ctrl_reg[`WDT_STOP_DIS_BIT] <= wdt_ctrl_reg[`WDT_STOP_DIS_BIT] |
                                               bus_req.wdata[`WDT_STOP_DIS_BIT];  // see R12
        end
    end

    // reload latches follow software writes, and take the fixed values on an auto reload so that
    // the prescaler wraps back to FF and the full two-round wait is kept whatever software left there
    always_ff @(posedge clk) begin
        if (!nrst) begin
            pre_reload_reg <= `PRESCALER12_RESET;
            t1_reload_reg  <= `TIMER1_RESET;
        end else if (auto_reload) begin
            pre_reload_reg <= `PRESCALER12_STOP_LD;  // see R07
            t1_reload_reg  <= `TIMER1_STOP_LOAD;  // see R07
        end else begin
            if (wr_pre) begin
                pre_reload_reg <= bus_req.wdata;
            end
            if (wr_t1) begin
                t1_reload_reg <= bus_req.wdata;
            end
        end
    end

    // watchdog keeps running through the stabilizing wait, so a long wait can trip it
    always_ff @(posedge clk) begin
        if (!nrst) begin
            wdt_cnt_reg   <= {2'h0, 6'(`WDT_CTRL_RESET), `WDT_PRELOAD_LOW};
            wdt_underflow <= 1'b0;
        end else begin
            wdt_underflow <= 1'b0;
            if (bus_req.wr && bus_req.addr == `ADDR_WDT_CTRL) begin
                wdt_cnt_reg <= {2'h0, bus_req.wdata[5:0], `WDT_PRELOAD_LOW};
            end else if (osc_tick && state_reg != ST_STOPPED) begin  // see R11
                if (wdt_cnt_reg == 16'h0000) begin
                    wdt_underflow <= 1'b1;
                    wdt_cnt_reg   <= {2'h0, wdt_ctrl_reg[5:0], `WDT_PRELOAD_LOW};
                end else begin
                    wdt_cnt_reg <= wdt_cnt_reg - 16'h0001;
                end
            end
        end
    end

    // clock gate and oscillator enables come straight from flops
    always_ff @(posedge clk) begin
        if (!nrst) begin
            cpu_clk_en  <= 1'b1;
            main_osc_en <= 1'b1;  // see R03
            sub_osc_en  <= 1'b0;  // see R03
            sys_clk_sub <= 1'b0;  // see R03
        end else begin
            cpu_clk_en  <= (state_next == ST_RUN);  // see R10
            main_osc_en <= (state_next != ST_STOPPED) && !cpum_reg[`CPUM_MAIN_STOP_BIT];  // see R06
            sub_osc_en  <= (state_next != ST_STOPPED) && cpum_reg[`CPUM_SUB_DRIVE_BIT];  // see R05
            sys_clk_sub <= cpum_reg[`CPUM_SYS_SUB_BIT];
        end
    end

    // read data stands in the cycle after the strobe only; unmapped reads give zero
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rd_data <= 8'h00;
        end else if (bus_req.rd) begin
            case (bus_req.addr)
                `ADDR_CPU_MODE:    rd_data <= cpum_reg;
                `ADDR_PORT_CTRL2:  rd_data <= pctl2_reg;
                `ADDR_WDT_CTRL:    rd_data <= wdt_ctrl_reg;
                `ADDR_TIMER1:      rd_data <= t1_cnt;
                `ADDR_PRESCALER12: rd_data <= pre_cnt;
                default:           rd_data <= 8'h00;
            endcase
        end else begin
            rd_data <= 8'h00;
        end
    end

    // helper counting oscillator ticks spent in the stabilizing wait
    logic [15:0] stab_ticks_reg;
    logic        reload_seen_reg;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            stab_ticks_reg  <= 16'h0000;
            reload_seen_reg <= 1'b0;
        end else if (stop_release) begin
            stab_ticks_reg  <= 16'h0000;
            reload_seen_reg <= auto_reload;
        end else if (state_reg == ST_STABILIZE && osc_tick && stab_ticks_reg != 16'hFFFF) begin
            stab_ticks_reg <= stab_ticks_reg + 16'h0001;
        end
    end

    sequence s_stop_entry;
        state_reg == ST_RUN && stop_instruction && stop_ok;
    endsequence
    sequence s_released;
        state_reg == ST_STOPPED && ext_rise;
    endsequence
    sequence s_stab_done;
        state_reg == ST_STABILIZE && t1_under;
    endsequence

    // the required wait scales with the divider, so shortened builds still check its length

    AST_CPUM_KEPT: assert property (@(posedge clk) disable iff (!nrst)  // see R01
        state_reg == ST_STABILIZE && !(bus_req.wr) |=> $stable(cpum_reg))
        else $error("cpu mode register changed during stop release");
    AST_STAB_LEN: assert property (@(posedge clk) disable iff (!nrst)  // see R02
        s_stab_done ##0 reload_seen_reg && !sys_clk_sub
        |-> stab_ticks_reg >= 16'(`STAB_MAIN_CYCLES * PREDIV / `PREDIV_DEFAULT))
        else $error("stabilizing wait shorter than required");
    AST_RESET_MAIN: assert property (@(posedge clk)  // see R03
        !nrst |=> main_osc_en && !sub_osc_en && !sys_clk_sub && state_reg == ST_RUN)
        else $error("reset did not restore main oscillator");
    AST_SUB_DRIVE: assert property (@(posedge clk) disable iff (!nrst)  // see R05
        state_next != ST_STOPPED && cpum_reg[`CPUM_SUB_DRIVE_BIT] |=> sub_osc_en)
        else $error("sub oscillator dropped with drive bit set");
    AST_STOP_HALT: assert property (@(posedge clk) disable iff (!nrst)  // see R06
        s_stop_entry |=> !main_osc_en && !sub_osc_en && !cpu_clk_en)
        else $error("oscillator running in stop");
    AST_STOP_HOLD: assert property (@(posedge clk) disable iff (!nrst)  // see R06
        state_reg == ST_STOPPED && !ext_rise |=> !main_osc_en && !sub_osc_en)
        else $error("oscillator restarted without external interrupt");
    AST_OSC_RESTART: assert property (@(posedge clk) disable iff (!nrst)  // see R06
        s_released ##0 !cpum_reg[`CPUM_MAIN_STOP_BIT] |=> main_osc_en)
        else $error("main oscillator not restarted on stop release");
    AST_AUTO_LOAD: assert property (@(posedge clk) disable iff (!nrst)  // see R07
        s_released ##0 !pctl2_reg[`PCTL2_NO_RELOAD_BIT] |=> t1_cnt == 8'h01 && pre_cnt == 8'hFF)
        else $error("fixed stop reload values not loaded");
    AST_NO_RELOAD: assert property (@(posedge clk) disable iff (!nrst)  // see R09
        s_released ##0 pctl2_reg[`PCTL2_NO_RELOAD_BIT] |=> $stable(t1_cnt) && $stable(pre_cnt))
        else $error("counters changed despite reload inhibit");
    AST_CLK_HELD: assert property (@(posedge clk) disable iff (!nrst)  // see R10
        s_released |=> !cpu_clk_en && state_reg == ST_STABILIZE)
        else $error("cpu clock released before timer 1 underflow");
    AST_CLK_WAIT: assert property (@(posedge clk) disable iff (!nrst)  // see R10
        state_reg == ST_STABILIZE && !t1_under |=> !cpu_clk_en)
        else $error("cpu clock released during stabilizing wait");
    AST_CLK_BACK: assert property (@(posedge clk) disable iff (!nrst)  // see R10
        s_stab_done |=> cpu_clk_en && state_reg == ST_RUN)
        else $error("cpu clock not returned after timer 1 underflow");
    AST_WDT_RUNS: assert property (@(posedge clk) disable iff (!nrst)  // see R11
        state_reg == ST_STABILIZE && osc_tick && !bus_req.wr && wdt_cnt_reg != 16'h0000
        |=> wdt_cnt_reg == $past(wdt_cnt_reg) - 16'h0001)
        else $error("watchdog paused during stop release");
    AST_STOPDIS_STICKY: assert property (@(posedge clk) disable iff (!nrst)  // see R12
        wdt_ctrl_reg[`WDT_STOP_DIS_BIT] |=> wdt_ctrl_reg[`WDT_STOP_DIS_BIT])
        else $error("stop disable bit cleared by software");
endmodule

//--- bench/osc_model.sv
// behavioural main and sub resonators that sit on the clock pins of the block
// assumes enables come from the block; a stopped resonator holds its pin low
module osc_model #(
    parameter int MAIN_HALF = 123,
    parameter int SUB_HALF  = 287
) (
    input  wire logic main_en,
    input  wire logic sub_en,
    input  wire logic slow,
    output logic      main_out,
    output logic      sub_out
);
    timeunit 1ns;
    timeprecision 1ns;

    // main resonator: pin stands still while disabled, slow doubles its period
    initial begin
        main_out = 1'b0;
        #7;
        forever begin
            #(slow ? 2 * MAIN_HALF : MAIN_HALF);
            main_out = main_en ? ~main_out : 1'b0;
        end
    end

    // sub resonator, phase unrelated to the main one
    initial begin
        sub_out = 1'b0;
        #13;
        forever begin
            #(SUB_HALF);
            sub_out = sub_en ? ~sub_out : 1'b0;
        end
    end
endmodule

//--- bench/tb_stop_wait_clock_restore.sv
// self-checking bench for the stop and wait clock control block
// assumes the package and constants header are compiled first; timer chain shortened to one tick per step
`include "clk_ctrl_consts.svh"
module tb_stop_wait_clock_restore;
    timeunit 1ns;
    timeprecision 1ns;
    import clk_ctrl_pkg::*;

    logic       clk;
    logic       nrst;
    bus_req_t   req;
    logic [7:0] rd_data;
    logic       stop_instruction;
    logic       wait_instruction;
    logic       ext_irq;
    logic       int_irq;
    logic       main_clock_input;
    logic       sub_clock_input;
    logic       cpu_clk_en;
    logic       main_osc_en;
    logic       sub_osc_en;
    logic       sys_clk_sub;
    logic       wdt_underflow;
    logic       slow;
    int         err_total;
    int         checks_done;
    int         ticks;
    int         wdt_seen;
    int         n;
    logic [7:0] p;

    stop_wait_clock_restore #(.PREDIV(1)) dut (
        .clk              (clk),
        .nrst             (nrst),
        .bus_req          (req),
        .rd_data          (rd_data),
        .stop_instruction (stop_instruction),
        .wait_instruction (wait_instruction),
        .ext_irq          (ext_irq),
        .int_irq          (int_irq),
        .main_clock_input (main_clock_input),
        .sub_clock_input  (sub_clock_input),
        .cpu_clk_en       (cpu_clk_en),
        .main_osc_en      (main_osc_en),
        .sub_osc_en       (sub_osc_en),
        .sys_clk_sub      (sys_clk_sub),
        .wdt_underflow    (wdt_underflow)
    );

    osc_model osc (
        .main_en  (main_osc_en),
        .sub_en   (sub_osc_en),
        .slow     (slow),
        .main_out (main_clock_input),
        .sub_out  (sub_clock_input)
    );

    // system clock, 40 ns period
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // tick and watchdog pulse counters used by the stabilizing checks
    always @(posedge main_clock_input) ticks++;
    always @(posedge clk) if (wdt_underflow === 1'b1) wdt_seen++;

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic idle(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        req.wr <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk);
        req.addr <= a;
        req.rd   <= 1'b1;
        @(posedge clk);
        req.rd <= 1'b0;
        #1 chk("rd_data", e, rd_data);
    endtask

    task automatic instr(input bit is_stop);
        @(posedge clk);
        if (is_stop) stop_instruction <= 1'b1;
        else wait_instruction <= 1'b1;
        @(posedge clk);
        stop_instruction <= 1'b0;
        wait_instruction <= 1'b0;
    endtask

    // release stop by an external edge and count oscillator ticks until the cpu clock returns
    task automatic stab(input int lo, input int hi);
        @(posedge clk);
        ext_irq <= 1'b1;
        ticks = 0;
        wdt_seen = 0;
        n = 0;
        repeat (4) @(posedge clk);
        ext_irq <= 1'b0;
        // sample a settled output one step after each edge; only the first test runs in the time step of the edge
        while (cpu_clk_en !== 1'b1 && n < 20000) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("stab_done", 8'h01, 8'(cpu_clk_en === 1'b1));
        chk("stab_ticks_in_range", 8'h01, 8'(ticks >= lo && ticks <= hi));
    endtask

    // watchdog: a hang counts as a mismatch
    initial begin
        #(40 * 60000);
        err_total++;
        conclude();
    end

    initial begin
        req = '0;
        nrst = 1'b0;
        stop_instruction = 1'b0;
        wait_instruction = 1'b0;
        ext_irq = 1'b0;
        int_irq = 1'b0;
        slow = 1'b0;
        err_total = 0;
        checks_done = 0;
        void'($urandom(54916));
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        // reset values and an unmapped read; the free-running prescaler is read before its first tick
        rd(`ADDR_PRESCALER12, `PRESCALER12_RESET);
        rd(`ADDR_CPU_MODE, `CPUM_RESET);
        rd(`ADDR_PORT_CTRL2, `PCTL2_RESET);
        rd(`ADDR_WDT_CTRL, `WDT_CTRL_RESET);
        rd(`ADDR_TIMER1, `TIMER1_RESET);
        rd(16'h0040 + 16'($urandom_range(0, 255)), 8'h00);
        chk("cpu_clk_en", 8'h01, 8'(cpu_clk_en));
        chk("main_osc_en", 8'h01, 8'(main_osc_en));
        // sub drive bit on and off
        wr(`ADDR_CPU_MODE, 8'h08);
        idle(2);
        chk("sub_osc_en", 8'h01, 8'(sub_osc_en));
        wr(`ADDR_CPU_MODE, 8'h00);
        idle(2);
        chk("sub_osc_en", 8'h00, 8'(sub_osc_en));
        // stop with both oscillators, auto reload overrides the small software counts
        wr(`ADDR_CPU_MODE, 8'h08);
        wr(`ADDR_WDT_CTRL, 8'h00);
        wr(`ADDR_TIMER1, 8'h05);
        wr(`ADDR_PRESCALER12, 8'h03);
        instr(1);
        idle(3);
        chk("main_osc_en", 8'h00, 8'(main_osc_en));
        chk("cpu_clk_en", 8'h00, 8'(cpu_clk_en));
        stab(2 * 256, 2 * 256 + 2);
        chk("wdt_in_stab", 8'h01, 8'(wdt_seen > 0));
        chk("main_osc_en", 8'h01, 8'(main_osc_en));
        chk("sub_osc_en", 8'h01, 8'(sub_osc_en));
        rd(`ADDR_CPU_MODE, 8'h08);
        // reload inhibited: software counts set the wait; on-chip irq may not release stop
        p = 8'($urandom_range(3, 10));
        slow = 1'b1;
        wr(`ADDR_PORT_CTRL2, 8'h40);
        wr(`ADDR_TIMER1, 8'h02);
        wr(`ADDR_PRESCALER12, p);
        rd(`ADDR_PORT_CTRL2, 8'h40);
        instr(1);
        @(posedge clk);
        int_irq <= 1'b1;
        @(posedge clk);
        int_irq <= 1'b0;
        idle(4);
        chk("cpu_clk_en", 8'h00, 8'(cpu_clk_en));
        stab(2 * (p + 1), 4 * (p + 1) + 2);
        slow = 1'b0;
        // wait released by the on-chip interrupt
        instr(0);
        idle(3);
        chk("cpu_clk_en", 8'h00, 8'(cpu_clk_en));
        @(posedge clk);
        int_irq <= 1'b1;
        @(posedge clk);
        int_irq <= 1'b0;
        idle(4);
        chk("cpu_clk_en", 8'h01, 8'(cpu_clk_en));
        // stop disable bit cannot be cleared, stop then ignored
        wr(`ADDR_WDT_CTRL, 8'h7F);
        wr(`ADDR_WDT_CTRL, 8'h3F);
        rd(`ADDR_WDT_CTRL, 8'h7F);
        instr(1);
        idle(4);
        chk("cpu_clk_en", 8'h01, 8'(cpu_clk_en));
        // sub clock as system clock with main stopped, wait, then reset
        wr(`ADDR_CPU_MODE, 8'hA8);
        idle(3);
        chk("sys_clk_sub", 8'h01, 8'(sys_clk_sub));
        chk("main_osc_en", 8'h00, 8'(main_osc_en));
        instr(0);
        idle(2);
        // reset held low for 20 system clock cycles, only about three main oscillator periods
        nrst <= 1'b0;
        idle(20);
        chk("main_osc_en", 8'h01, 8'(main_osc_en));
        chk("sub_osc_en", 8'h00, 8'(sub_osc_en));
        chk("sys_clk_sub", 8'h00, 8'(sys_clk_sub));
        nrst <= 1'b1;
        rd(`ADDR_WDT_CTRL, `WDT_CTRL_RESET);
        chk("cpu_clk_en", 8'h01, 8'(cpu_clk_en));
        conclude();
    end
endmodule
